// ### hw/boot_led_ctrl.v
// power-up mode selection and status indicators for a bus data logger
// assumes one 250 MHz clock, srst held from power-on; firmware reports events as one-cycle pulses
`timescale 1ns/1ps
`include "boot_led_consts.vh"

module boot_led_ctrl #(
  parameter [31:0] blink_half = `BLINK_HALF_CYC,
  parameter [31:0] pulse_len = `PULSE_CYC
) (
  input wire clock,
  input wire srst,
  input wire usb_vbus,
  input wire update_button,
  input wire boot_done,
  input wire cfg_valid,
  input wire cfg_invalid,
  input wire default_written,
  input wire autobaud_cfg,
  input wire baud_found,
  input wire bus_traffic,
  input wire card_write,
  input wire host_access,
  input wire card_error,
  input wire image_valid,
  input wire image_official,
  output reg [1:0] mode,
  output reg storage_host_en,
  output reg serial_en,
  output reg cfg_read_req,
  output reg cfg_default_req,
  output reg dfu_en,
  output reg image_accept,
  output reg image_reject,
  output reg led_green,
  output reg led_yellow,
  output reg led_red
);
  localparam [2:0] ph_boot = 3'h0;
  localparam [2:0] ph_cfg = 3'h1;
  localparam [2:0] ph_blink = 3'h2;
  localparam [2:0] ph_baud = 3'h3;
  localparam [2:0] ph_run = 3'h4;

  localparam [31:0] settle_full = `SETTLE_CYC;
  localparam [31:0] blinks_full = `BLINK_COUNT;
  localparam [15:0] settle_cyc = settle_full[15:0];
  localparam [1:0] blinks = blinks_full[1:0];

  // pins from outside: two flops before use
  reg vbus_s1_reg;
  reg vbus_s2_reg;
  reg btn_s1_reg;
  reg btn_s2_reg;
  always @(posedge clock) begin
    if (srst) begin
      vbus_s1_reg <= 1'b0;
      vbus_s2_reg <= 1'b0;
      btn_s1_reg <= 1'b0;
      btn_s2_reg <= 1'b0;
    end else begin
      vbus_s1_reg <= usb_vbus;
      vbus_s2_reg <= vbus_s1_reg;
      btn_s1_reg <= update_button;
      btn_s2_reg <= btn_s1_reg;
    end
  end

  reg [15:0] settle_reg;
  reg [2:0] phase_reg;
  reg [31:0] blink_cnt_reg;
  reg [1:0] blinks_left_reg;
  reg blink_on_reg;
  reg blink_red_reg;
  reg error_reg;

  // one stretcher per activity source: 0 bus traffic, 1 card write, 2 host access
  wire [2:0] act_trig;
  wire [2:0] act_on;
  wire in_run;
  wire traffic_on;
  wire write_on;
  wire access_on;

  assign in_run = (phase_reg == ph_run);

  // events outside the run phase are dropped, so boot-time activity leaves no stale glow
  assign act_trig[0] = bus_traffic && mode == `MODE_LOG && in_run;
  assign act_trig[1] = card_write && mode == `MODE_LOG && in_run;
  assign act_trig[2] = host_access && mode == `MODE_HOST && in_run;
  assign traffic_on = act_on[0];
  assign write_on = act_on[1];
  assign access_on = act_on[2];

  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : act_gen
      led_pulse #(.len(pulse_len)) stretch (
        .clock(clock),
        .srst(srst),
        .trig(act_trig[g]),
        .active(act_on[g])
      );
    end
  endgenerate

  // button wins over usb presence so an update can be forced with the cable in
  wire settled;
  assign settled = (settle_reg == settle_cyc);

  // mode is taken once after settling and then frozen until the next power-on reset
  always @(posedge clock) begin
    if (srst) begin
      settle_reg <= 16'h0;
      mode <= `MODE_BOOT;
    end else if (mode == `MODE_BOOT) begin
      if (!settled) begin
        settle_reg <= settle_reg + 16'h1;
      end else if (btn_s2_reg) begin
        mode <= `MODE_UPDATE;
      end else if (vbus_s2_reg) begin
        mode <= `MODE_HOST;
      end else begin
        mode <= `MODE_LOG;
      end
    end
  end

  // boot and configuration sequence
  always @(posedge clock) begin
    if (srst) begin
      phase_reg <= ph_boot;
      blink_cnt_reg <= 32'h0;
      blinks_left_reg <= 2'h0;
      blink_on_reg <= 1'b0;
      blink_red_reg <= 1'b0;
      cfg_read_req <= 1'b0;
      cfg_default_req <= 1'b0;
    end else begin
      cfg_read_req <= 1'b0;
      cfg_default_req <= 1'b0;
      case (phase_reg)
        ph_boot: begin
          if (boot_done && mode != `MODE_BOOT) begin
            if (mode == `MODE_LOG) begin
              phase_reg <= ph_cfg;
              cfg_read_req <= 1'b1;
            end else begin
              phase_reg <= ph_run;
            end
          end
        end
        ph_cfg: begin
          // firmware reports invalid once, so one default write is asked for
          if (cfg_invalid) begin
            cfg_default_req <= 1'b1;
          end
          if (cfg_valid || default_written) begin
            phase_reg <= ph_blink;
            blink_red_reg <= default_written;
            blinks_left_reg <= blinks;
            blink_on_reg <= 1'b1;
            blink_cnt_reg <= blink_half;
          end
        end
        ph_blink: begin
          // each blink is an on half then an off half; leave after the last off half
          if (blink_cnt_reg > 32'h1) begin
            blink_cnt_reg <= blink_cnt_reg - 32'h1;
          end else begin
            blink_cnt_reg <= blink_half;
            if (blink_on_reg) begin
              blink_on_reg <= 1'b0;
              blinks_left_reg <= blinks_left_reg - 2'h1;
            end else if (blinks_left_reg != 2'h0) begin
              blink_on_reg <= 1'b1;
            end else begin
              // the loaded setting is only looked at here
              phase_reg <= autobaud_cfg ? ph_baud : ph_run;
            end
          end
        end
        ph_baud: begin
          if (baud_found) begin
            phase_reg <= ph_run;
          end
        end
        default: begin
          phase_reg <= ph_run;
        end
      endcase
    end
  end

  // card errors latch; only a power cycle clears them
  always @(posedge clock) begin
    if (srst) begin
      error_reg <= 1'b0;
    end else if (card_error && mode != `MODE_BOOT && mode != `MODE_UPDATE) begin
      error_reg <= 1'b1;
    end
  end

  // usb function selection and firmware gate
  reg storage_host_en_next;
  reg serial_en_next;
  reg dfu_en_next;
  reg image_accept_next;
  reg image_reject_next;

  always @* begin
    storage_host_en_next = (mode == `MODE_HOST);
    // vbus only rises after logging began, since mode is frozen first
    serial_en_next = (mode == `MODE_LOG) && vbus_s2_reg;
    dfu_en_next = (mode == `MODE_UPDATE);
    image_accept_next = 1'b0;
    image_reject_next = 1'b0;
    if (image_valid) begin
      // an unreleased image is refused even in update mode
      if (image_official && mode == `MODE_UPDATE) begin
        image_accept_next = 1'b1;
      end else begin
        image_reject_next = 1'b1;
      end
    end
  end

  // registered so the usb function lines never glitch while mode settles
  always @(posedge clock) begin
    if (srst) begin
      storage_host_en <= 1'b0;
      serial_en <= 1'b0;
      dfu_en <= 1'b0;
      image_accept <= 1'b0;
      image_reject <= 1'b0;
    end else begin
      storage_host_en <= storage_host_en_next;
      serial_en <= serial_en_next;
      dfu_en <= dfu_en_next;
      image_accept <= image_accept_next;
      image_reject <= image_reject_next;
    end
  end

  // indicator drive; error wins over everything except update mode
  reg led_green_next;
  reg led_yellow_next;
  reg led_red_next;

  always @* begin
    led_green_next = 1'b1;
    led_yellow_next = 1'b0;
    led_red_next = 1'b0;
    if (mode == `MODE_UPDATE) begin
      led_green_next = 1'b0;
      led_red_next = 1'b1;
    end else if (error_reg) begin
      led_green_next = 1'b0;
      led_yellow_next = 1'b1;
      led_red_next = 1'b1;
    end else if (phase_reg == ph_blink) begin
      led_red_next = blink_red_reg && blink_on_reg;
      led_yellow_next = !blink_red_reg && blink_on_reg;
    end else if (phase_reg == ph_baud) begin
      led_yellow_next = 1'b1;
    end else if (in_run && mode == `MODE_HOST) begin
      led_red_next = access_on;
    end else if (in_run && mode == `MODE_LOG) begin
      led_yellow_next = traffic_on;
      led_red_next = write_on;
    end
  end

  // every indicator leaves from a plain flop
  always @(posedge clock) begin
    if (srst) begin
      led_green <= 1'b1;
      led_yellow <= 1'b0;
      led_red <= 1'b0;
    end else begin
      led_green <= led_green_next;
      led_yellow <= led_yellow_next;
      led_red <= led_red_next;
    end
  end
endmodule

// ### inc/boot_led_consts.vh
// constants for the boot mode selector and status indicator block
// assumes a 250 MHz system clock; included by bare name
`ifndef BOOT_LED_CONSTS_VH
`define BOOT_LED_CONSTS_VH

`define CLK_MHZ 250
// indicator blink half period and activity pulse length, in microseconds
`define BLINK_HALF_US 250000
`define BLINK_HALF_CYC (`BLINK_HALF_US * `CLK_MHZ)
`define PULSE_US 20000
`define PULSE_CYC (`PULSE_US * `CLK_MHZ)
`define BLINK_COUNT 3
// settle time before straps are sampled, microseconds
`define SETTLE_US 10
`define SETTLE_CYC (`SETTLE_US * `CLK_MHZ)

// mode codes
`define MODE_BOOT 2'h0
`define MODE_HOST 2'h1
`define MODE_LOG 2'h2
`define MODE_UPDATE 2'h3

`endif

// ### hw/led_pulse.v
// retriggerable pulse stretcher for one indicator
// event input is on the system clock; output stays high for len cycles
`timescale 1ns/1ps
`include "boot_led_consts.vh"

module led_pulse #(
  parameter [31:0] len = `PULSE_CYC
) (
  input wire clock,
  input wire srst,
  input wire trig,
  output wire active
);
  reg [31:0] count_reg;

  assign active = (count_reg != 32'h0);

  always @(posedge clock) begin
    if (srst) begin
      count_reg <= 32'h0;
    end else if (trig) begin
      count_reg <= len;
    end else if (count_reg != 32'h0) begin
      count_reg <= count_reg - 32'h1;
    end
  end
endmodule

// ### bench/boot_led_ctrl_asserts.sv
// port-level checker for the mode selector and status indicators
// assumes one clock and a synchronous active-high reset; bound from the bench top
`timescale 1ns/1ps
module boot_led_ctrl_asserts (
  input wire clock,
  input wire srst,
  input wire card_error,
  input wire host_access,
  input wire image_valid,
  input wire boot_done,
  input wire [1:0] mode,
  input wire storage_host_en,
  input wire serial_en,
  input wire cfg_read_req,
  input wire dfu_en,
  input wire image_accept,
  input wire image_reject,
  input wire led_green,
  input wire led_yellow,
  input wire led_red
);
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  // set once boot_done is seen with a mode chosen; in host and update modes the run phase starts on that edge
  logic booted_reg;
  always @(posedge clock) begin
    if (srst) booted_reg <= 1'b0;
    else if (boot_done && mode != 2'h0) booted_reg <= 1'b1;
  end
  sequence err_leds;
    !led_green && led_yellow && led_red;
  endsequence
  sequence boot_leds;
    led_green && !led_yellow && !led_red;
  endsequence
  boot_ind_a: assert property (mode == 2'h0 |-> boot_leds) else $error("boot indicators wrong");
  upd_ind_a: assert property (mode == 2'h3 |=> led_red && !led_green && !led_yellow)
    else $error("update indicators wrong");
  store_en_a: assert property (mode == 2'h1 |=> storage_host_en && !serial_en)
    else $error("storage off");
  log_lock_a: assert property (mode == 2'h2 |-> !storage_host_en) else $error("storage open");
  mode_keep_a: assert property (mode != 2'h0 |=> $stable(mode)) else $error("mode changed");
  card_err_a: assert property (card_error && (mode == 2'h1 || mode == 2'h2) |-> ##[1:4] err_leds)
    else $error("no error indication");
  host_red_a: assert property (host_access && mode == 2'h1 && booted_reg && led_green |-> ##[1:4] led_red)
    else $error("no access pulse");
  cfg_req_a: assert property (cfg_read_req |-> mode == 2'h2 ##1 !cfg_read_req) else $error("bad read request");
  img_gate_a: assert property (image_accept |-> dfu_en && mode == 2'h3) else $error("image taken");
  img_rej_a: assert property (image_valid && mode != 2'h3 |-> ##[0:3] image_reject) else $error("not refused");
endmodule

// ### bench/host_pc_model.sv
// usb host stand-in: supplies bus power and card accesses on request
// assumes the bench drives plugged and touch off the sampling edge
`timescale 1ns/1ps
module host_pc_model (
  input wire plugged,
  input wire touch,
  output wire usb_vbus,
  output wire host_access
);
  // no cable means no bus power, so the strap reads low
  assign usb_vbus = plugged;
  assign host_access = touch;
endmodule

// ### bench/boot_led_ctrl_tb_top.sv
// self-checking bench for the mode selector and status indicators
// assumes short blink and pulse counts; straps are driven before reset release
`timescale 1ns/1ps
module boot_led_ctrl_tb_top;
  logic clock = 0, srst = 1, plugged = 0, touch = 0, update_button = 0, boot_done = 0, cfg_valid = 0;
  logic cfg_invalid = 0, default_written = 0, autobaud_cfg = 0, baud_found = 0, bus_traffic = 0;
  logic card_write = 0, card_error = 0, image_valid = 0, image_official = 0;
  wire [1:0] mode;
  wire usb_vbus, host_access, storage_host_en, serial_en, cfg_read_req, cfg_default_req, dfu_en;
  wire image_accept, image_reject, led_green, led_yellow, led_red;
  wire [2:0] leds = {led_green, led_yellow, led_red};
  int err_count = 0, n_checks = 0;
  always #2 clock = ~clock;
  host_pc_model host (.plugged, .touch, .usb_vbus, .host_access);
  boot_led_ctrl #(.blink_half(8), .pulse_len(4)) DUT (.clock, .srst, .usb_vbus, .update_button, .boot_done,
    .cfg_valid, .cfg_invalid, .default_written, .autobaud_cfg, .baud_found, .bus_traffic, .card_write,
    .host_access, .card_error, .image_valid, .image_official, .mode, .storage_host_en, .serial_en,
    .cfg_read_req, .cfg_default_req, .dfu_en, .image_accept, .image_reject, .led_green, .led_yellow, .led_red);
  task end_of_test;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task chk(input string nm, input logic [2:0] exp, input logic [2:0] got);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task step(input int n);
    repeat (n) @(negedge clock);
  endtask
  task give_up(input logic stuck);
    if (stuck !== 1'b0) begin
      err_count++;
      $display("mismatch wait expected 0 seen %b", stuck);
      end_of_test;
    end
  endtask
  task automatic pulse(ref logic s);
    s = 1;
    step(1);
    s = 0;
  endtask
  task automatic power_up(input logic usb, input logic btn);
    int i;
    srst = 1;
    plugged = usb;
    update_button = btn;
    step(10);
    chk("boot leds", 3'h4, leds);
    srst = 0;
    // straps settle for about 2500 cycles before the decision
    for (i = 0; i < 3000 && mode === 2'h0; i++) step(1);
    give_up(mode === 2'h0);
  endtask
  task automatic t_host;
    int i;
    power_up(1, 0);
    step(1);
    chk("host mode", 3'h1, {1'b0, mode});
    chk("host enables", 3'h2, {dfu_en, storage_host_en, serial_en});
    pulse(boot_done);
    pulse(touch);
    for (i = 0; i < 4 && led_red !== 1'b1; i++) step(1);
    give_up(led_red !== 1'b1);
    chk("access leds", 3'h5, leds);
    plugged = 0;
    pulse(image_valid);
    step(3);
    chk("mode kept", 3'h1, {1'b0, mode});
    pulse(card_error);
    step(4);
    chk("error leds", 3'h3, leds);
    $display("test host done");
  endtask
  task automatic t_update;
    int i;
    power_up(1, 1);
    update_button = 0;
    step(1);
    chk("update mode", 3'h3, {1'b0, mode});
    chk("update leds", 3'h1, leds);
    pulse(image_valid);
    for (i = 0; i < 4 && image_reject !== 1'b1; i++) step(1);
    give_up(image_reject !== 1'b1);
    chk("unofficial refused", 3'h1, {2'b0, image_reject});
    image_official = 1;
    pulse(image_valid);
    for (i = 0; i < 4 && image_accept !== 1'b1; i++) step(1);
    give_up(image_accept !== 1'b1);
    chk("official taken", 3'h1, {2'b0, image_accept});
    image_official = 0;
    $display("test update done");
  endtask
  task automatic t_log(input logic inv);
    int i, n;
    logic b, p;
    autobaud_cfg = inv;
    power_up(0, 0);
    chk("log mode", 3'h2, {1'b0, mode});
    chk("log enables", 3'h0, {dfu_en, storage_host_en, serial_en});
    pulse(boot_done);
    for (i = 0; i < 4 && cfg_read_req !== 1'b1; i++) step(1);
    give_up(cfg_read_req !== 1'b1);
    chk("cfg read", 3'h1, {2'b0, cfg_read_req});
    if (inv) begin
      pulse(cfg_invalid);
      chk("default req", 3'h1, {2'b0, cfg_default_req});
      pulse(default_written);
    end else pulse(cfg_valid);
    n = 0;
    b = 0;
    for (i = 0; i < 70; i++) begin
      step(1);
      p = b;
      b = inv ? led_red : led_yellow;
      n += b && !p;
    end
    chk("blink count", 3'h3, n[2:0]);
    chk("after blink", inv ? 3'h6 : 3'h4, leds);
    if (inv) pulse(baud_found);
    step(3);
    pulse(bus_traffic);
    step(3);
    chk("traffic leds", 3'h6, leds);
    step(8);
    pulse(card_write);
    step(3);
    chk("write leds", 3'h5, leds);
    plugged = 1;
    step(4);
    chk("late host", 3'h1, {dfu_en, storage_host_en, serial_en});
    $display("test log done");
  endtask
  initial begin
    t_host;
    t_update;
    t_log(0);
    t_log(1);
    end_of_test;
  end
endmodule
bind boot_led_ctrl boot_led_ctrl_asserts chk (.clock, .srst, .card_error, .host_access, .image_valid, .boot_done, .mode,
  .storage_host_en, .serial_en, .cfg_read_req, .dfu_en, .image_accept, .image_reject, .led_green, .led_yellow,
  .led_red);
